/* adcoc_pkg.sv */
`default_nettype none
package adcoc_pkg;

  localparam int CLK_MHZ          = 40;
  localparam int T_CONV_TEMP_NS   = 27000;
  localparam int T_CONV_EXT_NS    = 9000;
  localparam int RES_W            = 10;
  localparam int THR_W            = 8;
  localparam int BYTE_W           = 8;
  localparam int CH_W             = 3;
  localparam int STEP_W           = 7;
  localparam int BIT_W            = 4;
  localparam int PIN_N            = 5;

  // Longest conversion times, rounded down to whole cycles.
  localparam int CONV_TEMP_CYC    = (T_CONV_TEMP_NS * CLK_MHZ) / 1000;
  localparam int CONV_EXT_CYC     = (T_CONV_EXT_NS * CLK_MHZ) / 1000;

  // Two cycles of the budget go to starting and finishing the sequence.
  localparam logic [STEP_W-1:0] STEP_TEMP = 7'((CONV_TEMP_CYC - 2) / RES_W);
  localparam logic [STEP_W-1:0] STEP_EXT  = 7'((CONV_EXT_CYC - 2) / RES_W);

  localparam logic [RES_W-1:0]  DAC_MID     = 10'h200;
  localparam logic [BIT_W-1:0]  BIT_TOP     = 4'h9;
  localparam logic [BIT_W-1:0]  BIT_LAST    = 4'h7;
  localparam logic [CH_W-1:0]   CH_TEMP     = 3'h0;
  localparam logic [CH_W-1:0]   CH_RST      = 3'h0;
  localparam logic [CH_W-1:0]   CH_THRESH   = 3'h7;
  localparam logic [THR_W-1:0]  THR_RST     = 8'hFF;
  localparam logic [BYTE_W-1:0] BYTE_RST    = 8'h00;
  localparam logic [RES_W-1:0]  RES_RST     = 10'h000;

  localparam int PIN_CONV = 4;
  localparam int PIN_CS   = 3;
  localparam int PIN_RDWR = 2;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN  = 0;

endpackage
`default_nettype wire

/* adcoc_sar.sv */
`timescale 1ns/1ps
`default_nettype none
module adcoc_sar
  import adcoc_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             start_in,
  input  wire logic             temp_mode_in,
  input  wire logic             comp_in,
  output var  logic [RES_W-1:0] dac_code_out,
  output var  logic [RES_W-1:0] result_out,
  output var  logic             done_out
);

  logic              active_reg;
  logic [BIT_W-1:0]  bit_reg;
  logic [STEP_W-1:0] step_reg;
  logic [STEP_W-1:0] step_len_reg;

  // The comparator reads high when the held input is at or above the trial code.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      active_reg   <= 1'b0;
      bit_reg      <= BIT_TOP;
      step_reg     <= '0;
      step_len_reg <= STEP_EXT;
      dac_code_out <= RES_RST;
      result_out   <= RES_RST;
      done_out     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !active_reg) begin
        active_reg   <= 1'b1;
        bit_reg      <= BIT_TOP;
        step_reg     <= '0;
        step_len_reg <= temp_mode_in ? STEP_TEMP : STEP_EXT;
        dac_code_out <= DAC_MID;
      end else if (active_reg) begin
        if (step_reg == step_len_reg - 7'h01) begin
          step_reg <= '0;
          if (bit_reg == '0) begin
            active_reg <= 1'b0;
            done_out   <= 1'b1;
            result_out <= {dac_code_out[RES_W-1:1], comp_in};
            dac_code_out[0] <= comp_in;
          end else begin
            bit_reg                   <= bit_reg - 4'h1;
            dac_code_out[bit_reg]     <= comp_in;
            dac_code_out[bit_reg - 4'h1] <= 1'b1;
          end
        end else begin
          step_reg <= step_reg + 7'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* adcoc_ctrl.sv */
// Contract
// - A convert-start falling edge while not busy begins one 10-bit conversion.
// - That falling edge moves the track-and-hold from track into hold.
// - Conversion end returns the track-and-hold to tracking.
// - Convert-start low at conversion end powers down; high keeps power.
// - Busy is high for the whole conversion, low otherwise.
// - Channel 0 result above the 8-bit threshold drives the flag low.
// - Rising read/write select with chip select low releases the flag high.
// - Serial activity is ignored unless chip select is low.
// - Data shifts out on falling, in on rising serial clock edges.
// - Data out floats on read/write select falling or chip select rising.
// - Temperature conversion within 27 us, external channel within 9 us.
`timescale 1ns/1ps
`default_nettype none
module adcoc_ctrl
  import adcoc_pkg::*;
(
  input  wire logic             CLK_IN,
  input  wire logic             RST_B_IN,
  input  wire logic             CONVERT_START_N_IN,
  input  wire logic             CS_N_IN,
  input  wire logic             RD_WR_IN,
  input  wire logic             SCLK_IN,
  input  wire logic             DIN_IN,
  input  wire logic             COMP_IN,
  output var  logic             BUSY_OUT,
  output var  logic             TRACK_HOLD_OUT,
  output var  logic             POWER_DOWN_OUT,
  output var  logic             OVERTEMP_FLAG_N_OUT,
  output var  logic             DOUT_OUT,
  output var  logic             DOUT_OE_N_OUT,
  output var  logic [CH_W-1:0]  CHANNEL_OUT,
  output var  logic [RES_W-1:0] DAC_CODE_OUT
);

  localparam int A_TMAX = 1080;
  localparam int A_EMAX = 360;

  logic [PIN_N-1:0]  sync1_reg;
  logic [PIN_N-1:0]  sync2_reg;
  logic [PIN_N-1:0]  prev_reg;
  logic              conv_s;
  logic              cs_s;
  logic              rdwr_s;
  logic              din_s;
  logic              conv_fall;
  logic              conv_rise;
  logic              cs_rise;
  logic              rdwr_rise;
  logic              rdwr_fall;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              conv_go;
  logic              sar_done;
  logic [RES_W-1:0]  sar_result;
  logic [CH_W-1:0]   conv_ch_reg;
  logic [RES_W-1:0]  result_reg;
  logic [RES_W-1:0]  out_sh_reg;
  logic [BYTE_W-1:0] in_sh_reg;
  logic [BYTE_W-1:0] wr_byte;
  logic [2:0]        in_cnt_reg;
  logic              thr_sel_reg;
  logic [THR_W-1:0]  overtemp_threshold_reg;
  logic              ot_set;
  logic              ot_clear;
  logic [10:0]       busy_cyc_reg;

  // Every pin passes two flip-flops; edges are taken from the second stage only.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg  <= '1;
    end else begin
      sync1_reg <= {CONVERT_START_N_IN, CS_N_IN, RD_WR_IN, SCLK_IN, DIN_IN};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign conv_s    = sync2_reg[PIN_CONV];
  assign cs_s      = sync2_reg[PIN_CS];
  assign rdwr_s    = sync2_reg[PIN_RDWR];
  assign din_s     = sync2_reg[PIN_DIN];
  assign conv_fall = prev_reg[PIN_CONV] & ~conv_s;
  assign conv_rise = ~prev_reg[PIN_CONV] & conv_s;
  assign cs_rise   = ~prev_reg[PIN_CS] & cs_s;
  assign rdwr_rise = ~prev_reg[PIN_RDWR] & rdwr_s;
  assign rdwr_fall = prev_reg[PIN_RDWR] & ~rdwr_s;
  assign sclk_rise = ~prev_reg[PIN_SCLK] & sync2_reg[PIN_SCLK];
  assign sclk_fall = prev_reg[PIN_SCLK] & ~sync2_reg[PIN_SCLK];

  // A falling edge while a conversion runs is ignored rather than restarting it.
  assign conv_go = conv_fall & ~BUSY_OUT;

  adcoc_sar u_sar (
    .clk_in       (CLK_IN),
    .rst_b_in     (RST_B_IN),
    .start_in     (conv_go),
    .temp_mode_in (CHANNEL_OUT == CH_TEMP),
    .comp_in      (COMP_IN),
    .dac_code_out (DAC_CODE_OUT),
    .result_out   (sar_result),
    .done_out     (sar_done)
  );

  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      BUSY_OUT       <= 1'b0;
      TRACK_HOLD_OUT <= 1'b0;
      conv_ch_reg    <= CH_RST;
      result_reg     <= RES_RST;
    end else if (conv_go) begin
      BUSY_OUT       <= 1'b1;
      TRACK_HOLD_OUT <= 1'b1;
      conv_ch_reg    <= CHANNEL_OUT;
    end else if (sar_done) begin
      BUSY_OUT       <= 1'b0;
      TRACK_HOLD_OUT <= 1'b0;
      result_reg     <= sar_result;
    end
  end

  // Counts busy cycles, so the long temperature budget needs no huge delay range.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      busy_cyc_reg <= '0;
    end else if (!BUSY_OUT) begin
      busy_cyc_reg <= '0;
    end else begin
      busy_cyc_reg <= busy_cyc_reg + 11'h001;
    end
  end

  // Power comes back on the next rising convert-start, ahead of the next falling edge.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      POWER_DOWN_OUT <= 1'b0;
    end else if (sar_done) begin
      POWER_DOWN_OUT <= ~conv_s;
    end else if (conv_rise || conv_go) begin
      POWER_DOWN_OUT <= 1'b0;
    end
  end

  assign ot_set   = sar_done && (conv_ch_reg == CH_TEMP)
                    && (sar_result[RES_W-1:RES_W-THR_W] > overtemp_threshold_reg);
  assign ot_clear = rdwr_rise && !cs_s;

  // A new over-temperature result wins over a read that clears in the same cycle.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      OVERTEMP_FLAG_N_OUT <= 1'b1;
    end else if (ot_set) begin
      OVERTEMP_FLAG_N_OUT <= 1'b0;
    end else if (ot_clear) begin
      OVERTEMP_FLAG_N_OUT <= 1'b1;
    end
  end

  assign wr_byte = {in_sh_reg[BYTE_W-2:0], din_s};

  // Write frames: an address byte picks the channel, or the threshold for the next byte.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      in_sh_reg              <= BYTE_RST;
      in_cnt_reg             <= '0;
      thr_sel_reg            <= 1'b0;
      CHANNEL_OUT            <= CH_RST;
      overtemp_threshold_reg <= THR_RST;
    end else if (cs_s) begin
      in_cnt_reg  <= '0;
      thr_sel_reg <= 1'b0;
    end else if (rdwr_s) begin
      in_cnt_reg <= '0;
    end else if (sclk_rise) begin
      in_sh_reg  <= wr_byte;
      in_cnt_reg <= in_cnt_reg + 3'h1;
      if (in_cnt_reg == BIT_LAST[2:0]) begin
        if (thr_sel_reg) begin
          overtemp_threshold_reg <= wr_byte;
          thr_sel_reg            <= 1'b0;
        end else if (wr_byte[CH_W-1:0] == CH_THRESH) begin
          thr_sel_reg <= 1'b1;
        end else begin
          CHANNEL_OUT <= wr_byte[CH_W-1:0];
        end
      end
    end
  end

  // Read frames shift the last result out, most significant bit first.
  always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      DOUT_OUT      <= 1'b0;
      DOUT_OE_N_OUT <= 1'b1;
      out_sh_reg    <= RES_RST;
    end else if (cs_s || rdwr_fall || cs_rise) begin
      DOUT_OE_N_OUT <= 1'b1;
    end else if (rdwr_rise) begin
      DOUT_OE_N_OUT <= 1'b0;
      DOUT_OUT      <= result_reg[RES_W-1];
      out_sh_reg    <= {result_reg[RES_W-2:0], 1'b0};
    end else if (sclk_fall && rdwr_s && !DOUT_OE_N_OUT) begin
      DOUT_OUT   <= out_sh_reg[RES_W-1];
      out_sh_reg <= {out_sh_reg[RES_W-2:0], 1'b0};
    end
  end

  a_start_busy: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    conv_fall && !BUSY_OUT |=> BUSY_OUT && !POWER_DOWN_OUT)
    else $error("Conversion did not start on convert-start falling edge.");

  a_hold_busy: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    TRACK_HOLD_OUT == BUSY_OUT)
    else $error("Track-and-hold state differs from busy.");

  a_track_done: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    sar_done |=> !TRACK_HOLD_OUT && !BUSY_OUT && result_reg == $past(sar_result))
    else $error("Conversion end did not resume tracking with result.");

  a_power_down: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    sar_done |=> POWER_DOWN_OUT == !$past(conv_s))
    else $error("Power-down does not follow convert-start at conversion end.");

  a_temp_time: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    BUSY_OUT && conv_ch_reg == CH_TEMP |-> busy_cyc_reg < 11'(A_TMAX))
    else $error("Temperature conversion took too long.");

  a_ext_time: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    conv_go && CHANNEL_OUT != CH_TEMP |=> BUSY_OUT [*8] ##[1:A_EMAX] !BUSY_OUT)
    else $error("External conversion busy window is wrong.");

  a_ot_set: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    ot_set |=> !OVERTEMP_FLAG_N_OUT)
    else $error("Over-temperature flag not driven low.");

  a_ot_clear: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    ot_clear && !ot_set |=> OVERTEMP_FLAG_N_OUT)
    else $error("Over-temperature flag not released by read.");

  a_cs_idle: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    cs_s |=> DOUT_OE_N_OUT && $stable(CHANNEL_OUT) && $stable(overtemp_threshold_reg))
    else $error("Serial port acted while deselected.");

  a_dout_float: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    rdwr_fall || cs_rise |=> DOUT_OE_N_OUT)
    else $error("Data out not released.");

  a_shift_out: assert property (@(posedge CLK_IN) disable iff (!RST_B_IN)
    sclk_fall && rdwr_s && !cs_s && !DOUT_OE_N_OUT && !rdwr_rise
    |=> DOUT_OUT == $past(out_sh_reg[RES_W-1]))
    else $error("Data out did not shift on falling serial clock.");

endmodule
`default_nettype wire

/* adcoc_mcu.sv */
`timescale 1ns/1ps
`default_nettype none
module adcoc_mcu (
  input  wire logic clk_in,
  input  wire logic sdo_in,
  output var  logic conv_n_out,
  output var  logic cs_n_out,
  output var  logic rd_wr_out,
  output var  logic sclk_out,
  output var  logic din_out
);
  initial begin
    conv_n_out = 1'b1;
    cs_n_out = 1'b1;
    rd_wr_out = 1'b0;
    sclk_out = 1'b1;
    din_out = 1'b0;
  end

  // Every change lands a fixed 2 ns after a rising edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic set_conv(input logic v);
    conv_n_out = v;
  endtask

  task automatic set_cs(input logic v);
    cs_n_out = v;
  endtask

  // Each clock phase lasts four cycles so the synchronisers see every edge.
  task automatic put_byte(input logic [7:0] b);
    rd_wr_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sclk_out = 1'b0;
      din_out = b[i];
      tick(4);
      sclk_out = 1'b1;
      tick(4);
    end
    din_out = ~din_out;
  endtask

  // The caller waits for busy to fall before reading the result.
  task automatic get_word(output logic [9:0] w);
    rd_wr_out = 1'b1;
    tick(4);
    w[9] = sdo_in;
    for (int i = 8; i >= 0; i--) begin
      sclk_out = 1'b0;
      tick(4);
      w[i] = sdo_in;
      sclk_out = 1'b1;
      tick(4);
    end
  endtask

  task automatic end_read;
    rd_wr_out = 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

/* adc_conversion_overtemp_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_overtemp_ctrl_test;
  import adcoc_pkg::*;
  logic             clk;
  logic             rst_b;
  logic [RES_W-1:0] target;
  logic [RES_W-1:0] dac;
  logic [RES_W-1:0] word;
  logic [CH_W-1:0]  chan;
  logic             busy;
  logic             th;
  logic             pd;
  logic             flag_n;
  logic             dout;
  logic             oe_n;
  logic             sdo_last;
  wire logic        conv_n;
  wire logic        cs_n;
  wire logic        rd_wr;
  wire logic        sclk;
  wire logic        din;
  wire logic        sdo;
  wire logic        comp;
  int               miscompares;
  int               n_tests;

  // A released data line shows the inverse of its last value, never a stale copy.
  assign sdo = oe_n ? ~sdo_last : dout;
  always @(posedge clk) begin
    if (!rst_b) sdo_last <= 1'b0;
    else if (!oe_n) sdo_last <= dout;
  end

  // The held analog input is modelled by target; the comparator judges it against the trial code.
  assign comp = target >= dac;

  adcoc_mcu mcu (
    .clk_in     (clk),
    .sdo_in     (sdo),
    .conv_n_out (conv_n),
    .cs_n_out   (cs_n),
    .rd_wr_out  (rd_wr),
    .sclk_out   (sclk),
    .din_out    (din)
  );

  adcoc_ctrl uut (
    .CLK_IN              (clk),
    .RST_B_IN            (rst_b),
    .CONVERT_START_N_IN  (conv_n),
    .CS_N_IN             (cs_n),
    .RD_WR_IN            (rd_wr),
    .SCLK_IN             (sclk),
    .DIN_IN              (din),
    .COMP_IN             (comp),
    .BUSY_OUT            (busy),
    .TRACK_HOLD_OUT      (th),
    .POWER_DOWN_OUT      (pd),
    .OVERTEMP_FLAG_N_OUT (flag_n),
    .DOUT_OUT            (dout),
    .DOUT_OE_N_OUT       (oe_n),
    .CHANNEL_OUT         (chan),
    .DAC_CODE_OUT        (dac)
  );

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (exp !== got) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic select_channel(input logic [7:0] b);
    mcu.set_cs(1'b0);
    mcu.put_byte(b);
    mcu.set_cs(1'b1);
    mcu.tick(4);
    check("channel", 16'(b[2:0]), 16'(chan));
  endtask

  // A second start pulse in mid-conversion must not stretch or restart it.
  task automatic convert(input logic keep_low, input int len, input logic poke);
    int n;
    n = 0;
    mcu.set_conv(1'b0);
    while (busy !== 1'b1 && n < 8) begin
      mcu.tick(1);
      n++;
    end
    check("busy_delay", 16'd3, 16'(n));
    check("hold", 16'd1, 16'(th));
    if (!keep_low) mcu.set_conv(1'b1);
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      if (poke && n == 100) mcu.set_conv(1'b0);
      if (poke && n == 110) mcu.set_conv(1'b1);
      mcu.tick(1);
      n++;
    end
    check("busy_len", 16'(len), 16'(n));
    check("track", 16'd0, 16'(th));
    check("power_down", 16'(keep_low), 16'(pd));
  endtask

  task automatic read_result(input logic [RES_W-1:0] exp);
    mcu.set_cs(1'b0);
    mcu.tick(2);
    mcu.get_word(word);
    check("result", 16'(exp), 16'(word));
    check("flag_clear", 16'd1, 16'(flag_n));
    mcu.end_read();
    check("release", 16'd1, 16'(oe_n));
    mcu.set_cs(1'b1);
    mcu.tick(2);
  endtask

  task automatic ext_channel;
    select_channel(8'h01);
    target = 10'h2A5;
    convert(1'b0, RES_W * STEP_EXT + 1, 1'b1);
    check("flag_ext", 16'd1, 16'(flag_n));
    read_result(10'h2A5);
  endtask

  task automatic temp_over;
    mcu.set_cs(1'b0);
    mcu.put_byte(8'h07);
    mcu.put_byte(8'h40);
    mcu.set_cs(1'b1);
    mcu.tick(4);
    select_channel(8'h00);
    target = 10'h104;
    convert(1'b1, RES_W * STEP_TEMP + 1, 1'b0);
    check("flag_set", 16'd0, 16'(flag_n));
    mcu.set_conv(1'b1);
    mcu.tick(4);
    check("power_up", 16'd0, 16'(pd));
    mcu.put_byte(8'hFF);
    mcu.get_word(word);
    check("ignored_flag", 16'd0, 16'(flag_n));
    check("ignored_oe", 16'd1, 16'(oe_n));
    mcu.end_read();
    read_result(10'h104);
  endtask

  // The threshold compare is strict, so an equal code leaves the flag high.
  task automatic temp_equal;
    target = 10'h103;
    convert(1'b0, RES_W * STEP_TEMP + 1, 1'b0);
    check("flag_equal", 16'd1, 16'(flag_n));
    read_result(10'h103);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(20000 * 25);
    miscompares++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    target = 10'h000;
    miscompares = 0;
    n_tests = 0;
    mcu.tick(2);
    rst_b = 1'b1;
    mcu.tick(2);
    check("rst_flag", 16'd1, 16'(flag_n));
    check("rst_busy", 16'd0, 16'(busy));
    check("rst_oe", 16'd1, 16'(oe_n));
    ext_channel();
    temp_over();
    temp_equal();
    results();
  end
endmodule
`default_nettype wire
